// ===== hdl/psbi_cfg.svh
// Constants of the pipelined static memory bus interface.
`ifndef PSBI_CFG_SVH
`define PSBI_CFG_SVH

`define PSBI_ADDR_W      20
`define PSBI_DATA_W      18
`define PSBI_LANE_W      9
`define PSBI_LANES       2
`define PSBI_DEPTH       1048576
`define PSBI_BEAT_W      2
`define PSBI_BURST_LEN   4
`define PSBI_BEAT_FIRST  2'h0
`define PSBI_BEAT_STEP   2'h1
`define PSBI_ADDR_RST    20'h00000
`define PSBI_LANES_RST   2'h0

`endif

// ===== hdl/psbi_pkg.sv
// Types of the pipelined static memory bus interface.
`include "psbi_cfg.svh"

package psbi_pkg;

  typedef logic [`PSBI_ADDR_W-1:0] psbi_addr_t;
  typedef logic [`PSBI_DATA_W-1:0] psbi_data_t;
  typedef logic [`PSBI_LANE_W-1:0] psbi_lane_t;
  typedef logic [`PSBI_BEAT_W-1:0] psbi_beat_t;
  typedef logic [`PSBI_LANES-1:0]  psbi_mask_t;

  typedef enum logic
  {
    PSBI_LINEAR,
    PSBI_INTERLEAVED
  } psbi_order_e;

  // One accepted access waiting for its data cycle.
  typedef struct packed
  {
    logic       live;
    logic       write;
    psbi_addr_t addr;
    psbi_mask_t lanes;
  } psbi_access_s;

  // The burst that advance cycles continue.
  typedef struct packed
  {
    logic       live;
    logic       write;
    psbi_addr_t base;
    psbi_beat_t beat;
  } psbi_burst_s;

endpackage

// ===== hdl/psbi_sram_port.sv
// Pipelined static memory with flow-through outputs and a four-beat burst counter.
`timescale 1ns/1ps
`include "psbi_cfg.svh"

// Operation
// - Data moves one cycle after its command
// - Inputs registered, read data flows through
// - Output enable releases pins at once
// - Clock gate high freezes all registers
// - Gated edge leaves outputs unchanged
// - Any select missing on load deselects
// - Deselect still finishes accepted transfers
// - Pins release after deselect or write
// - Four beats from one start address
// - Order input picks linear or interleaved
// - Load takes address, advance steps counter
// - Address captured on enabled selected load
// - Deselected load ends running burst
// - Advance cycles ignore address pins
// - Read or write chosen at load
// - Reads and writes alternate without gaps
// - Array of 1M words, 18 bits
// - Two byte lane write enables
// - Output drive controlled internally, synchronously
// - Order high interleaved, low linear, static
// - Lane enables sampled per beat, written later
// - Second select active high, else identical
module psbi_sram_port
  import psbi_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Command pins.
  input  wire psbi_addr_t word_address_bus,
  input  wire logic       clock_gate_n,
  input  wire logic       advance_or_load,
  input  wire logic       access_read,
  input  wire logic       chip_select_first_n,
  input  wire logic       chip_select_second,
  input  wire logic       chip_select_third_n,
  input  wire logic       byte_lane_low_write_n,
  input  wire logic       byte_lane_high_write_n,
  input  wire logic       burst_order_select,
  input  wire logic       output_enable_n,
  // Data pins.
  input  wire psbi_data_t data_pins_in,
  output      psbi_data_t data_pins_out,
  output      logic       data_pins_oe
);

  // ==========================================================================
  // Command decode
  // ==========================================================================

  logic         selected;
  logic         running;
  logic         loading;
  psbi_order_e  order;
  psbi_mask_t   pin_lanes;
  psbi_burst_s  burst;
  psbi_burst_s  next_burst;
  psbi_access_s pend;
  psbi_access_s next_pend;
  psbi_beat_t   next_beat;
  psbi_beat_t   low_bits;

  // The second select has opposite polarity but the same role.
  assign selected = !chip_select_first_n
                  && chip_select_second
                  && !chip_select_third_n;

  assign running = !clock_gate_n;
  assign loading = !advance_or_load;

  // Order is read directly; the controller keeps it static.
  assign order = burst_order_select ? PSBI_INTERLEAVED : PSBI_LINEAR;

  assign pin_lanes = ~{byte_lane_high_write_n, byte_lane_low_write_n};

  assign next_beat = burst.beat + `PSBI_BEAT_STEP;

  // Only the two low address bits follow the beat count.
  always_comb
  begin
    unique case (order)
      PSBI_LINEAR:      low_bits = burst.base[`PSBI_BEAT_W-1:0] + next_beat;
      PSBI_INTERLEAVED: low_bits = burst.base[`PSBI_BEAT_W-1:0] ^ next_beat;
    endcase
  end

  // ==========================================================================
  // Next access and burst state
  // ==========================================================================

  always_comb
  begin
    next_burst = burst;
    next_pend  = '0;
    if (loading)
    begin
      if (selected)
      begin
        next_burst.live  = 1'b1;
        next_burst.write = !access_read;
        next_burst.base  = word_address_bus;
        next_burst.beat  = `PSBI_BEAT_FIRST;
        next_pend.live   = 1'b1;
        next_pend.write  = !access_read;
        next_pend.addr   = word_address_bus;
        next_pend.lanes  = access_read ? `PSBI_LANES_RST : pin_lanes;
      end
      else
      begin
        // A deselect starts nothing and ends the burst.
        next_burst.live = 1'b0;
      end
    end
    else if (burst.live)
    begin
      // Address pins are not looked at on advance cycles.
      next_burst.beat = next_beat;
      next_pend.live  = 1'b1;
      next_pend.write = burst.write;
      next_pend.addr  = {burst.base[`PSBI_ADDR_W-1:`PSBI_BEAT_W], low_bits};
      next_pend.lanes = burst.write ? pin_lanes : `PSBI_LANES_RST;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      burst.live  <= 1'b0;
      burst.write <= 1'b0;
      burst.base  <= `PSBI_ADDR_RST;
      burst.beat  <= `PSBI_BEAT_FIRST;
    end
    else if (running)
    begin
      burst <= next_burst;
    end
  end

  // The access stage is the one-cycle delay between command and data.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend.live  <= 1'b0;
      pend.write <= 1'b0;
      pend.addr  <= `PSBI_ADDR_RST;
      pend.lanes <= `PSBI_LANES_RST;
    end
    else if (running)
    begin
      pend <= next_pend;
    end
  end

  // ==========================================================================
  // Array, one memory per byte lane
  // ==========================================================================

  // Write data is taken in the data cycle, so an accepted write lands even
  // when the same edge carries a deselect.
  genvar lane;
  generate
    for (lane = 0; lane < `PSBI_LANES; lane = lane + 1)
    begin : g_lane
      psbi_lane_t store [0:`PSBI_DEPTH-1];

      always_ff @(posedge clk_sys)
      begin
        if (running && pend.live && pend.write && pend.lanes[lane])
        begin
          store[pend.addr] <= data_pins_in[lane*`PSBI_LANE_W +: `PSBI_LANE_W];
        end
      end

      // Flow-through read path with no output register.
      assign data_pins_out[lane*`PSBI_LANE_W +: `PSBI_LANE_W] = store[pend.addr];

      lane_write_lands_a : assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (running && pend.live && pend.write && pend.lanes[lane])
        |=> store[$past(pend.addr)] == $past(data_pins_in[lane*`PSBI_LANE_W +: `PSBI_LANE_W]))
        else $error("Enabled byte lane was not written.");
    end
  endgenerate

  // ==========================================================================
  // Output drive
  // ==========================================================================

  // Drive follows the access stage; the enable pin can only cut it off.
  assign data_pins_oe = pend.live && !pend.write
                      && !output_enable_n;

  // ==========================================================================
  // Checks
  // ==========================================================================

  oe_cuts_drive_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    output_enable_n |-> !data_pins_oe)
    else $error("Data pins driven while output enable is inactive.");

  read_next_cycle_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && selected && access_read)
    ##1 !output_enable_n |-> data_pins_oe)
    else $error("Read did not drive pins in the following cycle.");

  gated_edge_holds_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !running |=> $stable(pend) && $stable(burst))
    else $error("State changed on an edge with the clock gate inactive.");

  gated_output_stable_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (!running && $stable(output_enable_n)) ##1 $stable(output_enable_n)
    |-> $stable(data_pins_oe))
    else $error("Output drive changed across a gated edge.");

  deselect_no_access_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && !selected) |=> !pend.live && !burst.live)
    else $error("Deselect started an access.");

  deselect_finishes_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && pend.live && pend.write && pend.lanes[0] && loading && !selected)
    |=> g_lane[0].store[$past(pend.addr)] == $past(data_pins_in[`PSBI_LANE_W-1:0]))
    else $error("Accepted write lost on a deselect edge.");

  release_after_write_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && (!selected || !access_read)) |=> !data_pins_oe)
    else $error("Pins driven one cycle after deselect or write.");

  burst_addr_step_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && selected && !burst_order_select)
    ##1 (running && !loading)
    |=> pend.live && pend.addr[1:0] == $past(pend.addr[1:0]) + 2'h1)
    else $error("Linear burst beat did not advance by one.");

  interleave_order_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && !loading && burst.live && burst_order_select)
    |=> pend.addr[1:0] == ($past(burst.base[1:0]) ^ ($past(burst.beat) + 2'h1)))
    else $error("Interleaved burst address wrong.");

  upper_bits_fixed_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && !loading && burst.live)
    |=> pend.addr[19:2] == $past(burst.base[19:2]))
    else $error("Burst changed address bits above the low two.");

  load_captures_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && selected)
    |=> burst.base == $past(word_address_bus) && burst.beat == 2'h0)
    else $error("Load did not capture the address pins.");

  advance_ignores_pins_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && !loading) |=> $stable(burst.base))
    else $error("Address register changed on an advance cycle.");

  deselect_ends_burst_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && !selected) ##1 (running && !loading)
    |=> !pend.live)
    else $error("Burst continued after a deselected load.");

  direction_at_load_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && selected)
    |=> pend.write == !$past(access_read))
    else $error("Access direction does not match the load cycle.");

  no_turnaround_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && selected && !access_read)
    ##1 (running && loading && selected && access_read)
    ##1 !output_enable_n |-> data_pins_oe)
    else $error("Read after write lost a cycle to turnaround.");

  lanes_per_beat_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && !loading && burst.live && burst.write)
    |=> pend.lanes == ~$past({byte_lane_high_write_n, byte_lane_low_write_n}))
    else $error("Burst write beat took wrong lane enables.");

  second_select_polarity_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && !chip_select_second) |=> !pend.live)
    else $error("Low second select failed to deselect.");

  advance_idle_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && !loading && !burst.live) |=> !pend.live)
    else $error("Advance with no burst started an access.");

  write_beat_quiet_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && !loading && burst.live && burst.write) |=> !data_pins_oe)
    else $error("Pins driven during a burst write beat.");

  read_beat_drives_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && !loading && burst.live && !burst.write)
    ##1 !output_enable_n |-> data_pins_oe)
    else $error("Burst read beat did not drive the pins.");

  linear_order_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && !loading && burst.live && !burst_order_select)
    |=> pend.addr[1:0] == $past(burst.base[1:0]) + $past(burst.beat) + 2'h1)
    else $error("Linear burst address wrong.");

  lanes_at_load_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && selected && !access_read)
    |=> pend.lanes == ~$past({byte_lane_high_write_n, byte_lane_low_write_n}))
    else $error("Load write took wrong lane enables.");

  read_lanes_quiet_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && loading && selected && access_read)
    |=> pend.lanes == `PSBI_LANES_RST)
    else $error("Read load enabled byte lane writes.");

  beat_wraps_a : assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (running && !loading && burst.live && burst.beat == 2'h3)
    |=> burst.beat == `PSBI_BEAT_FIRST)
    else $error("Burst counter did not wrap after four beats.");

endmodule

// ===== sim/pipelined_sram_bus_interface_test.sv
// Self-checking bench of the pipelined static memory port.
`timescale 1ns/1ps

// ==========================================================
// Bench.
module pipelined_sram_bus_interface_test;
  import psbi_pkg::*;
  logic        clk_sys, sys_rst, gate_n, adv, rd, cs1_n, cs2, cs3_n;
  logic        lo_n, hi_n, ord, oe_n, ctl_drive, oe;
  psbi_addr_t  addr, st_addr, b_base;
  psbi_data_t  din, dout, ctl_data;
  psbi_mask_t  st_lanes;
  psbi_beat_t  b_beat;
  logic        st_live = 1'b0;
  logic        b_live = 1'b0;
  logic        st_wr, b_wr;
  logic [31:0] seed = 32'hede9815a;
  int          n_fail = 0;
  int          n_checks = 0;
  psbi_data_t  mem [0:15];

  psbi_sram_port psbi_sram_port_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .word_address_bus(addr), .clock_gate_n(gate_n), .advance_or_load(adv),
    .access_read(rd), .chip_select_first_n(cs1_n), .chip_select_second(cs2),
    .chip_select_third_n(cs3_n), .byte_lane_low_write_n(lo_n),
    .byte_lane_high_write_n(hi_n), .burst_order_select(ord),
    .output_enable_n(oe_n), .data_pins_in(din), .data_pins_out(dout), .data_pins_oe(oe));

  psbi_ctrl_model psbi_ctrl_model_i (.clk_sys(clk_sys), .dev_oe(oe), .dev_out(dout),
    .ctl_drive(ctl_drive), .ctl_data(ctl_data), .wire_level(din));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function psbi_addr_t bstep(psbi_addr_t b, psbi_beat_t k, logic o);
    return {b[19:2], o ? b[1:0] ^ k : b[1:0] + k};
  endfunction

  // The stimulus only ever reaches sixteen words, so the model keeps just those.
  function logic [3:0] slot(psbi_addr_t a);
    return {a[19:18], a[1:0]};
  endfunction

  function psbi_data_t merge(psbi_data_t old, psbi_data_t nw, psbi_mask_t w);
    return {w[1] ? nw[17:9] : old[17:9], w[0] ? nw[8:0] : old[8:0]};
  endfunction

  task chk(input psbi_data_t seen, input psbi_data_t exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask

  task tally_and_finish();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Index 0 to 15 loads a full write of that word, 16 deselects, -1 draws at random.
  task drive(input int k);
    logic [31:0] r;
    r = xs();
    gate_n = (r[2:0] == 3'h0);
    adv = r[3];
    rd = r[4];
    cs1_n = (r[7:5] == 3'h0);
    cs2 = (r[10:8] != 3'h0);
    cs3_n = (r[13:11] == 3'h0);
    lo_n = r[14];
    hi_n = r[15];
    oe_n = (r[18:16] == 3'h0);
    addr = {r[20:19], 16'h0, r[22:21]};
    if (k >= 0)
    begin
      gate_n = 1'b0;
      adv = 1'b0;
      rd = 1'b0;
      cs1_n = (k >= 16);
      cs2 = 1'b1;
      cs3_n = 1'b0;
      lo_n = 1'b0;
      hi_n = 1'b0;
      addr = {k[3:2], 16'h0, k[1:0]};
    end
    r = xs();
    ctl_drive = st_live && st_wr;
    ctl_data = r[17:0];
  endtask

  task cyc(input int k);
    @(posedge clk_sys);
    if (sys_rst)
    begin
      st_live = 1'b0;
      b_live = 1'b0;
    end
    else if (!gate_n)
    begin
      if (st_live && st_wr)
        mem[slot(st_addr)] = merge(mem[slot(st_addr)], ctl_data, st_lanes);
      if (!adv && !cs1_n && cs2 && !cs3_n)
      begin
        b_live = 1'b1;
        b_wr = !rd;
        b_base = addr;
        b_beat = 2'h0;
      end
      else if (!adv)
        b_live = 1'b0;
      else if (b_live)
        b_beat++;
      st_live = b_live;
      st_wr = b_wr;
      st_addr = bstep(b_base, b_beat, ord);
      st_lanes = {~hi_n, ~lo_n};
    end
    #1;
    chk(psbi_data_t'(oe), psbi_data_t'(st_live && !st_wr && !oe_n));
    if (st_live && !st_wr)
      chk(dout, mem[slot(st_addr)]);
    drive(k);
  endtask

  // Each phase resets, preloads all sixteen words back to back, then runs at random.
  task run(input logic o, input int n);
    sys_rst = 1'b1;
    st_live = 1'b0;
    b_live = 1'b0;
    ord = o;
    repeat (20) cyc(16);
    sys_rst = 1'b0;
    for (int k = 0; k < 16; k++)
      cyc(k);
    repeat (n) cyc(-1);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    ord = 1'b0;
    drive(16);
    run(1'b0, 2500);
    run(1'b1, 2500);
    tally_and_finish();
  end

  initial
  begin
    #150000;
    n_fail++;
    tally_and_finish();
  end
endmodule

// ===== sim/psbi_ctrl_model.sv
// Controller-side model of the shared data wires.
`timescale 1ns/1ps

// ==========================================================
// Wire resolution.
module psbi_ctrl_model
  import psbi_pkg::*;
(
  // Clock.
  input  wire logic       clk_sys,
  // Device side.
  input  wire logic       dev_oe,
  input  wire psbi_data_t dev_out,
  // Controller side.
  input  wire logic       ctl_drive,
  input  wire psbi_data_t ctl_data,
  output      psbi_data_t wire_level
);
  psbi_data_t last;

  // An undriven bus shows the inverse of its last level, so stale data never matches.
  assign wire_level = dev_oe ? dev_out : ctl_drive ? ctl_data : ~last;

  always_ff @(posedge clk_sys)
  begin
    last <= wire_level;
  end
endmodule
